// ---- rtl/etoc_regs.vh ----
// register map, field positions and framing constants of the transmit overhead control
`ifndef ETOC_REGS_VH
`define ETOC_REGS_VH

// byte addresses
`define ETOC_ADDR_TRA 11'h5A0
`define ETOC_ADDR_SA4 11'h5A4
`define ETOC_ADDR_SA5 11'h5A8
`define ETOC_ADDR_SA6 11'h5AC
`define ETOC_ADDR_SA7 11'h5B0
`define ETOC_ADDR_SA8 11'h5B4
`define ETOC_ADDR_MMR 11'h600
`define ETOC_ADDR_T1C1 11'h604
`define ETOC_ADDR_SRC 11'h610
`define ETOC_ADDR_STAT 11'h614
`define ETOC_ADDR_T1C2 11'h618
`define ETOC_ADDR_CHEN 11'h61C
`define ETOC_SA_STRIDE 4

// reset values
`define ETOC_RST_BYTE 8'h00
`define ETOC_RST_CHEN 24'h000000

// tx_master_mode fields
`define ETOC_MMR_FMT_EN 7
`define ETOC_MMR_INIT 6
`define ETOC_MMR_SRST 1
`define ETOC_MMR_E1 0

// tx_t1_control_1 fields
`define ETOC_T1C1_CRC_TYPE 7
`define ETOC_T1C1_FPT 6
`define ETOC_T1C1_CPT 5
`define ETOC_T1C1_SSE 4
`define ETOC_T1C1_GLOBAL_BIT7_STUFFING 3
`define ETOC_T1C1_B8ZS 2
`define ETOC_T1C1_AIS 1
`define ETOC_T1C1_RAI 0

// overhead source select: entry i (0..4 = spare bits four..eight, 5 = remote alarm)
`define ETOC_SRC_RA 5
`define ETOC_OVH_ENTRIES 6

// status and second control register fields
`define ETOC_STAT_MF 0
`define ETOC_STAT_ACTIVE 1
`define ETOC_T1C2_B7ZS 0
`define ETOC_T1C2_RAI_TYPE 1

// framing
`define ETOC_E1_LAST_BIT 8'hFF
`define ETOC_T1_LAST_BIT 8'hC0
`define ETOC_T1_FRAME_BITS 9'h0C1
`define ETOC_E1_LAST_FRAME 5'h0F
`define ETOC_T1_LAST_FRAME 5'h17
`define ETOC_STUFF_DELAY 9'h008
`define ETOC_E1_FAS 7'h1B
`define ETOC_T1_FPS 6'h34
`define ETOC_CRC6_POLY 6'h03
`define ETOC_B8ZS_DATA 8'h1B
`define ETOC_B8ZS_VIOL 8'h12

`endif

// ---- rtl/etoc_line_encoder.v ----
// bipolar AMI line encoder with optional B8ZS substitution
`timescale 1ns/1ps
`include "etoc_regs.vh"
module etoc_line_encoder (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // bit stream
  input wire bit_tick,
  input wire bit_in,
  input wire b8zs_en,
  // bipolar line
  output wire pos_out,
  output wire neg_out
);

  reg [7:0] data_ff;
  reg [7:0] viol_ff;
  reg last_pos_ff;
  reg pos_ff;
  reg neg_ff;
  reg [7:0] nxt_data;
  reg [7:0] nxt_viol;

  // eight bits of look-ahead so a run of eight zeros is seen whole
  always @* begin
    nxt_data = {data_ff[6:0], bit_in};
    nxt_viol = {viol_ff[6:0], 1'b0};
    if (b8zs_en && (nxt_data == 8'h00)) begin
      nxt_data = `ETOC_B8ZS_DATA;
      nxt_viol = `ETOC_B8ZS_VIOL;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      data_ff <= 8'h00;
      viol_ff <= 8'h00;
      last_pos_ff <= 1'b0;
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
    end else if (bit_tick) begin
      data_ff <= nxt_data;
      viol_ff <= nxt_viol;
      if (!data_ff[7]) begin
        pos_ff <= 1'b0;
        neg_ff <= 1'b0;
      end else if (viol_ff[7]) begin
        // violation repeats the previous polarity
        pos_ff <= last_pos_ff;
        neg_ff <= ~last_pos_ff;
      end else begin
        pos_ff <= ~last_pos_ff;
        neg_ff <= last_pos_ff;
        last_pos_ff <= ~last_pos_ff;
      end
    end
  end

  assign pos_out = pos_ff;
  assign neg_out = neg_ff;

endmodule // etoc_line_encoder

// ---- rtl/etoc_tx_overhead_ctrl.v ----
// transmit overhead control of one LINE_STANDARD_SELECT formatter port
// Operation
// - remote alarm select set: send latched alarm-bit register, latched at multiframe start
// - alarm register bits 7..0 feed odd frames 15,13,..,1
// - spare bit four select set: send latched register, bit 7 frame 15 down to 1
// - spare bit five select set: send latched register, bit 7 frame 15 down to 1
// - spare bit six select set: send latched register, bit 7 frame 15 down to 1
// - spare bit seven select set: send latched register, bit 7 frame 15 down to 1
// - spare bit eight select set: send latched register, bit 7 frame 15 down to 1
// - every transmit multiframe boundary sets a sticky status flag
// - formatter enable at 0 holds formatter idle; at 1 everything runs
// - transmitter starts only after init done, if enable was 1 then
// - soft reset bit holds formatter in reset while 1
// - master mode bit 0 picks T1 (0) or E1 (1) for transmit only
// - crc type bit picks standard or Japanese CRC-6 in T1
// - F-bit pass-through takes F bits from the serial input
// - CRC pass-through samples CRC-6 bits from serial input at F-bit times
// - software signalling off never inserts signalling; on inserts per channel enables
// - bit 7 zero suppression off: no stuffing, global stuffing ignored
// - global stuffing stuffs every all-zero channel, else per-channel enables choose
// - B8ZS enable turns B8ZS line coding off or on
// - T1 AIS bit sends unframed all ones on the bipolar outputs
// - T1 remote alarm bit sends RAI of the configured type
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "etoc_regs.vh"
module etoc_tx_overhead_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // avalon-mm register slave
  input wire [10:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // line bit timing and serial data
  input wire tx_bit_tick,
  input wire serial_tx_data_in,
  input wire robbed_bit_in,
  // bipolar line outputs
  output wire bipolar_out_positive,
  output wire bipolar_out_negative
);

  // register file
  reg [7:0] ovh_ff [0:5];
  reg [7:0] ovh_lat_ff [0:5];
  reg [7:0] mmr_ff;
  reg [7:0] t1c1_ff;
  reg [7:0] src_ff;
  reg [7:0] t1c2_ff;
  reg [23:0] chen_ff;
  reg mf_flag_ff;

  // bus handshake
  reg wait_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;

  // formatter state
  reg active_ff;
  reg init_prev_ff;
  reg [7:0] bit_cnt_ff;
  reg [4:0] frame_cnt_ff;
  reg [7:0] stuff_sr_ff;
  reg [5:0] crc_ff;
  reg [5:0] crc_tx_ff;
  reg [3:0] fdl_cnt_ff;

  reg [7:0] nxt_stuff_sr;
  reg out_bit;
  reg framed_bit;
  reg [5:0] nxt_crc;
  reg crc_bit;

  wire [10:0] addr_word;
  wire req;
  wire wr_go;
  wire wr_b0;
  wire fmt_rst;
  wire e1_mode;
  wire tick;
  wire mf_start;
  wire last_bit;
  wire last_frame;
  wire [5:0] ovh_cur;
  wire [8:0] p_sum;
  wire [8:0] p_in;
  wire [8:0] p_in_m1;
  wire [4:0] chan_in;
  wire ch_last_in;
  wire [7:0] bit_m1;
  wire [4:0] chan_out;
  wire [2:0] bitidx_out;
  wire byte_zero;
  wire stuff_now;
  wire sig_frame;
  wire rai_on;
  wire ais_on;
  wire mf_clr;
  // frame patterns as nets so single bits can be picked out of them
  wire [6:0] fas_pat = `ETOC_E1_FAS;
  wire [5:0] fps_pat = `ETOC_T1_FPS;

  assign addr_word = {avs_address[10:2], 2'b00};
  assign req = avs_read | avs_write;
  // a write lands on the edge where the master sees waitrequest low
  assign wr_go = avs_write & ~wait_ff;
  assign wr_b0 = wr_go & avs_byteenable[0];

  // waitrequest drops for exactly one cycle per request, then rises again
  always @(posedge ref_clk) begin
    if (reset) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (avs_read & wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // plain control registers clear on reset
  always @(posedge ref_clk) begin
    if (reset) begin
      mmr_ff <= `ETOC_RST_BYTE;
      t1c1_ff <= `ETOC_RST_BYTE;
      src_ff <= `ETOC_RST_BYTE;
      t1c2_ff <= `ETOC_RST_BYTE;
    end else if (wr_b0) begin
      if (addr_word == `ETOC_ADDR_MMR) begin
        mmr_ff <= avs_writedata[7:0];
      end
      if (addr_word == `ETOC_ADDR_T1C1) begin
        t1c1_ff <= avs_writedata[7:0];
      end
      if (addr_word == `ETOC_ADDR_SRC) begin
        src_ff <= {2'b00, avs_writedata[5:0]};
      end
      if (addr_word == `ETOC_ADDR_T1C2) begin
        t1c2_ff <= {6'h00, avs_writedata[1:0]};
      end
    end
  end

  // per-channel enables, one byte lane per group of eight channels
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chen
      always @(posedge ref_clk) begin
        if (reset) begin
          chen_ff[gi*8 +: 8] <= `ETOC_RST_BYTE;
        end else if (wr_go && avs_byteenable[gi] && addr_word == `ETOC_ADDR_CHEN) begin
          chen_ff[gi*8 +: 8] <= avs_writedata[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // multiframe flag: hardware set wins over write-one-to-clear
  assign mf_clr = wr_b0 & (addr_word == `ETOC_ADDR_STAT) & avs_writedata[`ETOC_STAT_MF];
  always @(posedge ref_clk) begin
    if (reset) begin
      mf_flag_ff <= 1'b0;
    end else begin
      mf_flag_ff <= mf_start | (mf_flag_ff & ~mf_clr);
    end
  end

  // read mux
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr_word)
      `ETOC_ADDR_TRA: nxt_rdata[7:0] = ovh_ff[`ETOC_SRC_RA];
      `ETOC_ADDR_SA4: nxt_rdata[7:0] = ovh_ff[0];
      `ETOC_ADDR_SA5: nxt_rdata[7:0] = ovh_ff[1];
      `ETOC_ADDR_SA6: nxt_rdata[7:0] = ovh_ff[2];
      `ETOC_ADDR_SA7: nxt_rdata[7:0] = ovh_ff[3];
      `ETOC_ADDR_SA8: nxt_rdata[7:0] = ovh_ff[4];
      `ETOC_ADDR_MMR: nxt_rdata[7:0] = mmr_ff;
      `ETOC_ADDR_T1C1: nxt_rdata[7:0] = t1c1_ff;
      `ETOC_ADDR_SRC: nxt_rdata[7:0] = src_ff;
      `ETOC_ADDR_STAT: nxt_rdata[1:0] = {active_ff, mf_flag_ff};
      `ETOC_ADDR_T1C2: nxt_rdata[7:0] = t1c2_ff;
      `ETOC_ADDR_CHEN: nxt_rdata[23:0] = chen_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // soft reset is a level, held while the bit stays 1
  assign fmt_rst = reset | mmr_ff[`ETOC_MMR_SRST];

  // enable captured on the rising edge of init done
  always @(posedge ref_clk) begin
    if (fmt_rst) begin
      active_ff <= 1'b0;
      init_prev_ff <= 1'b0;
    end else begin
      init_prev_ff <= mmr_ff[`ETOC_MMR_INIT];
      if (!mmr_ff[`ETOC_MMR_INIT]) begin
        active_ff <= 1'b0;
      end else if (!init_prev_ff) begin
        active_ff <= mmr_ff[`ETOC_MMR_FMT_EN];
      end else begin
        // clearing the enable later parks the formatter
        active_ff <= active_ff & mmr_ff[`ETOC_MMR_FMT_EN];
      end
    end
  end

  // transmit line standard, independent of the receive side
  assign e1_mode = mmr_ff[`ETOC_MMR_E1];
  assign tick = tx_bit_tick & active_ff;
  assign last_bit = e1_mode ? (bit_cnt_ff == `ETOC_E1_LAST_BIT)
                            : (bit_cnt_ff == `ETOC_T1_LAST_BIT);
  assign last_frame = e1_mode ? (frame_cnt_ff == `ETOC_E1_LAST_FRAME)
                              : (frame_cnt_ff == `ETOC_T1_LAST_FRAME);
  assign mf_start = tick & (bit_cnt_ff == 8'h00) & (frame_cnt_ff == 5'h00);

  always @(posedge ref_clk) begin
    if (fmt_rst) begin
      bit_cnt_ff <= 8'h00;
      frame_cnt_ff <= 5'h00;
    end else if (!active_ff) begin
      bit_cnt_ff <= 8'h00;
      frame_cnt_ff <= 5'h00;
    end else if (tick) begin
      bit_cnt_ff <= last_bit ? 8'h00 : bit_cnt_ff + 8'h01;
      if (last_bit) begin
        frame_cnt_ff <= last_frame ? 5'h00 : frame_cnt_ff + 5'h01;
      end
    end
  end

  // overhead registers, their multiframe copies and the bit for the current frame
  generate
    for (gi = 0; gi < `ETOC_OVH_ENTRIES; gi = gi + 1) begin : g_ovh
      localparam integer OVH_ADDR = (gi == `ETOC_SRC_RA) ? `ETOC_ADDR_TRA
                                    : `ETOC_ADDR_SA4 + gi * `ETOC_SA_STRIDE;
      always @(posedge ref_clk) begin
        if (reset) begin
          ovh_ff[gi] <= `ETOC_RST_BYTE;
        end else if (wr_b0 && addr_word == OVH_ADDR[10:0]) begin
          ovh_ff[gi] <= avs_writedata[7:0];
        end
      end
      // copy taken at multiframe start so mid-multiframe writes stay coherent
      always @(posedge ref_clk) begin
        if (fmt_rst) begin
          ovh_lat_ff[gi] <= `ETOC_RST_BYTE;
        end else if (mf_start) begin
          ovh_lat_ff[gi] <= ovh_ff[gi];
        end
      end
      // odd frame 2k+1 takes bit k
      assign ovh_cur[gi] = ovh_lat_ff[gi][frame_cnt_ff[3:1]];
    end
  endgenerate

  // serial input leads the line by eight bits so whole channel bytes can be stuffed
  assign p_sum = {1'b0, bit_cnt_ff} + `ETOC_STUFF_DELAY;
  assign p_in = (p_sum >= `ETOC_T1_FRAME_BITS) ? p_sum - `ETOC_T1_FRAME_BITS : p_sum;
  assign p_in_m1 = p_in - 9'h001;
  assign chan_in = p_in_m1[7:3];
  assign ch_last_in = (p_in != 9'h000) & (p_in[2:0] == 3'h0);
  assign byte_zero = ({stuff_sr_ff[6:0], serial_tx_data_in} == 8'h00);
  // stuffing gated by suppression enable, then global or per channel
  assign stuff_now = ~e1_mode & t1c2_ff[`ETOC_T1C2_B7ZS] & ch_last_in & byte_zero
                     & (t1c1_ff[`ETOC_T1C1_GLOBAL_BIT7_STUFFING] | chen_ff[chan_in]);

  always @* begin
    nxt_stuff_sr = {stuff_sr_ff[6:0], serial_tx_data_in};
    if (stuff_now) begin
      nxt_stuff_sr[1] = 1'b1;
    end
  end

  // output-side T1 position
  assign bit_m1 = bit_cnt_ff - 8'h01;
  assign chan_out = bit_m1[7:3];
  assign bitidx_out = bit_m1[2:0];
  assign sig_frame = (frame_cnt_ff == 5'h05) | (frame_cnt_ff == 5'h0B)
                     | (frame_cnt_ff == 5'h11) | (frame_cnt_ff == 5'h17);
  assign rai_on = t1c1_ff[`ETOC_T1C1_RAI];
  assign ais_on = ~e1_mode & t1c1_ff[`ETOC_T1C1_AIS];

  // bit placed on the line this tick
  always @* begin
    framed_bit = stuff_sr_ff[7];
    if (e1_mode) begin
      if (bit_cnt_ff == 8'h00) begin
        framed_bit = stuff_sr_ff[7];
      end else if (bit_cnt_ff < 8'h08 && !frame_cnt_ff[0]) begin
        framed_bit = fas_pat[3'h7 - bit_cnt_ff[2:0]];
      end else if (bit_cnt_ff == 8'h01) begin
        framed_bit = 1'b1;
      end else if (bit_cnt_ff == 8'h02) begin
        // remote alarm from the latched copy when selected
        framed_bit = src_ff[`ETOC_SRC_RA] ? ovh_cur[`ETOC_SRC_RA] : stuff_sr_ff[7];
      end else if (bit_cnt_ff < 8'h08) begin
        framed_bit = src_ff[bit_cnt_ff[2:0] - 3'h3] ? ovh_cur[bit_cnt_ff[2:0] - 3'h3]
                                                   : stuff_sr_ff[7];
      end
    end else if (bit_cnt_ff == 8'h00) begin
      if (t1c1_ff[`ETOC_T1C1_FPT]) begin
        framed_bit = stuff_sr_ff[7];
      end else begin
        case (frame_cnt_ff[1:0])
          2'b11: framed_bit = fps_pat[frame_cnt_ff[4:2]];
          // crc bits computed or passed through
          2'b01: framed_bit = t1c1_ff[`ETOC_T1C1_CPT] ? stuff_sr_ff[7]
                                                      : crc_tx_ff[3'h5 - frame_cnt_ff[4:2]];
          // data link carries the alarm pattern when selected
          default: framed_bit = (rai_on & ~t1c2_ff[`ETOC_T1C2_RAI_TYPE]) ? ~fdl_cnt_ff[3]
                                                                         : 1'b1;
        endcase
      end
    end else if (rai_on && t1c2_ff[`ETOC_T1C2_RAI_TYPE] && bitidx_out == 3'h1) begin
      // alternative alarm type: bit 2 of every channel zero
      framed_bit = 1'b0;
    end else if (t1c1_ff[`ETOC_T1C1_SSE] && chen_ff[chan_out] && sig_frame
                 && bitidx_out == 3'h7) begin
      // robbed-bit signalling only when software signalling is on
      framed_bit = robbed_bit_in;
    end
    out_bit = ais_on ? 1'b1 : framed_bit;
  end

  // standard crc treats F bits as ones, Japanese type uses them as sent
  always @* begin
    crc_bit = framed_bit;
    if (bit_cnt_ff == 8'h00 && !t1c1_ff[`ETOC_T1C1_CRC_TYPE]) begin
      crc_bit = 1'b1;
    end
    nxt_crc = mf_start ? 6'h00 : crc_ff;
    nxt_crc = {nxt_crc[4:0], 1'b0} ^ ((nxt_crc[5] ^ crc_bit) ? `ETOC_CRC6_POLY : 6'h00);
  end

  always @(posedge ref_clk) begin
    if (fmt_rst) begin
      stuff_sr_ff <= 8'h00;
      crc_ff <= 6'h00;
      crc_tx_ff <= 6'h00;
      fdl_cnt_ff <= 4'h0;
    end else if (tick) begin
      stuff_sr_ff <= nxt_stuff_sr;
      crc_ff <= nxt_crc;
      // previous superframe's remainder goes out in this one
      if (mf_start) begin
        crc_tx_ff <= crc_ff;
      end
      if (!e1_mode && bit_cnt_ff == 8'h00 && !frame_cnt_ff[0]) begin
        fdl_cnt_ff <= fdl_cnt_ff + 4'h1;
      end
    end
  end

  // disabled formatter keeps the line quiet
  etoc_line_encoder u_line_encoder (
    .ref_clk(ref_clk),
    .reset(fmt_rst | ~active_ff),
    .bit_tick(tick),
    .bit_in(out_bit),
    // B8ZS only on the T1 stream
    .b8zs_en(~e1_mode & t1c1_ff[`ETOC_T1C1_B8ZS]),
    .pos_out(bipolar_out_positive),
    .neg_out(bipolar_out_negative)
  );

endmodule // etoc_tx_overhead_ctrl

// ---- verification/etoc_tx_ovh_sva.sv ----
// port-level assertions for the transmit overhead control
`timescale 1ns/1ps
module etoc_tx_ovh_sva (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // register bus
  input wire [10:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // line side
  input wire tx_bit_tick,
  input wire bipolar_out_positive,
  input wire bipolar_out_negative
);
  reg [7:0] mmr_ff;
  reg [7:0] nxt_mmr;
  wire pulse = bipolar_out_positive || bipolar_out_negative;
  default clocking cb @(posedge ref_clk); endclocking
  // shadow of the master mode byte, taken only at the handshake edge
  always @* begin
    nxt_mmr = mmr_ff;
    if (avs_write && !avs_waitrequest && avs_address[10:2] == 9'h180 && avs_byteenable[0]) begin
      nxt_mmr = avs_writedata[7:0];
    end
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      mmr_ff <= 8'h00;
    end else begin
      mmr_ff <= nxt_mmr;
    end
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_reset_idle;
    reset |=> avs_waitrequest && !pulse && avs_readdata == 32'h00000000;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_handshake;
    disable iff (reset) s_req |=> s_ack;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("request not answered in one wait cycle");
  property p_ack_cause;
    disable iff (reset) $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("waitrequest dropped without a request");
  property p_upper_zero;
    disable iff (reset) avs_read && !avs_waitrequest |-> avs_readdata[31:24] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read byte not zero");
  property p_rails;
    disable iff (reset) !(bipolar_out_positive && bipolar_out_negative);
  endproperty
  a_rails: assert property (p_rails)
    else $error("both line rails high");
  property p_pulse_tick;
    disable iff (reset) $rose(pulse) |-> $past(tx_bit_tick);
  endproperty
  a_pulse_tick: assert property (p_pulse_tick)
    else $error("line pulse started without a bit tick");
  property p_soft_hold;
    disable iff (reset) mmr_ff[1] [*3] |-> !pulse;
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("line active during soft reset");
  property p_off_idle;
    disable iff (reset) !mmr_ff[7] [*3] |-> !pulse;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("line active with formatter disabled");
  property p_uninit_idle;
    disable iff (reset) !mmr_ff[6] && !$past(mmr_ff[6]) && !$past(mmr_ff[6], 2) |-> !pulse;
  endproperty
  a_uninit_idle: assert property (p_uninit_idle)
    else $error("line active before init done");
endmodule // etoc_tx_ovh_sva
bind etoc_tx_overhead_ctrl etoc_tx_ovh_sva etoc_tx_ovh_sva_i (
  .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_bit_tick(tx_bit_tick),
  .bipolar_out_positive(bipolar_out_positive), .bipolar_out_negative(bipolar_out_negative)
);

// ---- verification/etoc_line_partner.sv ----
// line-side partner: bit timing, serial data and robbed-bit source
`timescale 1ns/1ps
module etoc_line_partner (
  // clock
  input wire ref_clk,
  // bench control
  input wire run,
  input wire data_level,
  // toward the formatter
  output logic bit_tick,
  output logic ser_data,
  output logic robbed_bit
);
  logic phase;
  initial begin
    phase = 1'b0;
    bit_tick = 1'b0;
    ser_data = 1'b0;
    robbed_bit = 1'b0;
  end
  // one bit every two clocks; robbed bit keeps changing so stale values show
  // serial level also feeds passed-through framing bits
  always @(posedge ref_clk) begin
    phase <= run ? !phase : 1'b0;
    bit_tick <= run && !phase;
    ser_data <= data_level;
    robbed_bit <= 1'($urandom);
  end
endmodule // etoc_line_partner

// ---- verification/test_line_standard_select_tx_overhead_ctrl.sv ----
// self-checking bench for the transmit overhead control
`timescale 1ns/1ps
`include "etoc_regs.vh"
module test_line_standard_select_tx_overhead_ctrl;
  logic ref_clk, reset, avs_read, avs_write, run, lvl;
  logic avs_waitrequest, tick, ser, robbed, pos, neg;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, v;
  logic [3:0] avs_byteenable;
  logic [7:0] ra, src;
  logic [39:0] sa;
  logic cap [0:4199];
  int failures, check_count, ones, maxz, seed, d, p, ok, found;
  logic [10:0] regs [0:11] = '{`ETOC_ADDR_TRA, `ETOC_ADDR_SA4, `ETOC_ADDR_SA5, `ETOC_ADDR_SA6,
    `ETOC_ADDR_SA7, `ETOC_ADDR_SA8, `ETOC_ADDR_MMR, `ETOC_ADDR_T1C1, `ETOC_ADDR_SRC,
    `ETOC_ADDR_STAT, `ETOC_ADDR_T1C2, `ETOC_ADDR_CHEN};
  etoc_tx_overhead_ctrl etoc_tx_overhead_ctrl_i (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_bit_tick(tick), .serial_tx_data_in(ser),
    .robbed_bit_in(robbed), .bipolar_out_positive(pos), .bipolar_out_negative(neg));
  etoc_line_partner etoc_line_partner_i (.ref_clk(ref_clk), .run(run), .data_level(lvl),
    .bit_tick(tick), .ser_data(ser), .robbed_bit(robbed));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      failures++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] dt,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= dt;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    q = avs_readdata;
    check_num("bus wait bounded", 1, n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] dt);
    bus(1'b1, a, dt, 4'hF, rd);
  endtask
  task automatic rdchk(input string what, input logic [10:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, 4'hF, rd);
    check_reg(what, exp, rd & m);
  endtask
  // restart the formatter, activate it and record the decoded line
  task automatic run_line(input logic [7:0] mode, input logic [7:0] t1c, input logic l, input int n);
    int i, z;
    z = 0;
    wr(`ETOC_ADDR_MMR, 32'h00000002);
    rdchk("active in soft reset", `ETOC_ADDR_STAT, 32'h00000002, 32'h00000000);
    wr(`ETOC_ADDR_MMR, 32'h00000000);
    wr(`ETOC_ADDR_T1C1, {24'h000000, t1c});
    // enable and standard settled before init done
    wr(`ETOC_ADDR_MMR, {24'h000000, mode & 8'hBF});
    wr(`ETOC_ADDR_MMR, {24'h000000, mode});
    lvl <= l;
    run <= 1'b1;
    ones = 0;
    maxz = 0;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk iff tick === 1'b1);
      cap[i] = pos | neg;
      z = cap[i] ? 0 : z + 1;
      // early ticks only carry pipeline latency
      if (i >= 64) begin
        ones += cap[i];
        maxz = z > maxz ? z : maxz;
      end
    end
    run <= 1'b0;
  endtask
  function automatic logic e1_bit(input int p, input logic l);
    int f, b, k;
    logic [6:0] fas;
    fas = `ETOC_E1_FAS;
    f = (p / 256) % 16;
    b = p % 256;
    k = f / 2;
    if (b == 0 || b > 7) return l;
    if (f % 2 == 0) return fas[7 - b];
    if (b == 1) return 1'b1;
    if (b == 2) return src[5] ? ra[k] : l;
    return src[b - 3] ? sa[(b - 3) * 8 + k] : l;
  endfunction
  initial begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    $display("unexpected run length: expected end of tests, seen timeout");
    conclude();
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 11'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    run = 1'b0;
    lvl = 1'b0;
    failures = 0;
    check_count = 0;
    seed = $urandom(32'h93BB);
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int j = 0; j < 12; j++) begin
      rdchk("reset value", regs[j], 32'hFFFFFFFF, 32'h00000000);
    end
    rdchk("unmapped read", 11'h7FC, 32'hFFFFFFFF, 32'h00000000);
    $display("reset values done");
    for (int j = 0; j < 12; j++) begin
      if (j != 6 && j != 9) begin
        v = $urandom;
        wr(regs[j], v);
        // source select keeps six bits, second control two
        v &= j == 11 ? 32'hFFFFFF : j == 8 ? 32'h3F : j == 10 ? 32'h3 : 32'hFF;
        rdchk("register readback", regs[j], 32'hFFFFFFFF, v);
        wr(regs[j], 32'h00000000);
      end
    end
    wr(11'h7FC, 32'hFFFFFFFF);
    rdchk("unmapped after write", 11'h7FC, 32'hFFFFFFFF, 32'h00000000);
    bus(1'b1, `ETOC_ADDR_SA4, 32'h000000FF, 4'hE, rd);
    rdchk("lane 0 disabled write", `ETOC_ADDR_SA4, 32'hFFFFFFFF, 32'h00000000);
    $display("register access done");
    run_line(8'h41, 8'h00, 1'b1, 300);
    check_num("pulses while disabled", 0, ones);
    wr(`ETOC_ADDR_MMR, 32'h000000C1);
    rdchk("active without init edge", `ETOC_ADDR_STAT, 32'h00000002, 32'h00000000);
    $display("activation order done");
    for (int r = 0; r < 2; r++) begin
      ra = 8'($urandom);
      sa = {8'($urandom), 32'($urandom)};
      src = r ? 8'($urandom) & 8'h3F : 8'h3F;
      wr(`ETOC_ADDR_TRA, {24'h000000, ra});
      for (int k = 0; k < 5; k++) begin
        wr(`ETOC_ADDR_SA4 + 11'(k * 4), {24'h000000, sa[k * 8 +: 8]});
      end
      wr(`ETOC_ADDR_SRC, {24'h000000, src});
      run_line(8'hC1, 8'h00, r[0], 4160);
      found = 0;
      for (d = 0; d < 64 && found == 0; d++) begin
        ok = 1;
        for (p = 8; p < 4096; p++) begin
          if (cap[p + d] !== e1_bit(p, r[0])) ok = 0;
        end
        found = ok;
      end
      check_num("e1 multiframe overhead", 1, found);
      rdchk("status after multiframes", `ETOC_ADDR_STAT, 32'h00000003, 32'h00000003);
      wr(`ETOC_ADDR_STAT, 32'h00000001);
      rdchk("status after clear", `ETOC_ADDR_STAT, 32'h00000001, 32'h00000000);
      $display("e1 overhead pass %0d done", r);
    end
    run_line(8'hC0, 8'h02, 1'b0, 600);
    check_num("t1 alarm ones", 536, ones);
    // global stuffing asked for while suppression is still off
    run_line(8'hC0, 8'h68, 1'b0, 600);
    check_num("passed-through zero line", 0, ones);
    run_line(8'hC0, 8'h00, 1'b0, 600);
    check_num("internal framing ones", 1, ones > 0);
    run_line(8'hC0, 8'h64, 1'b0, 600);
    check_num("b8zs pulses", 1, ones > 0);
    check_num("b8zs zero run bounded", 1, maxz <= 7);
    // line ticks 55..590 hold 67 bit 7 positions, one per channel byte
    wr(`ETOC_ADDR_T1C2, 32'h00000001);
    run_line(8'hC0, 8'h68, 1'b0, 600);
    check_num("stuffed bit 7 ones", 67, ones);
    $display("t1 line options done");
    conclude();
  end
endmodule // test_line_standard_select_tx_overhead_ctrl
